// file: shared/dcirq_pkg.sv
// package: register map, field layout and carrier types of the completion interrupt block
package dcirq_pkg;

  // ---------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [11:0] OFF_ENABLE_BITS   = 12'h000;
  localparam logic [11:0] OFF_ENABLE_CLEAR  = 12'h004;
  localparam logic [11:0] OFF_ENABLE_SET    = 12'h008;
  localparam logic [11:0] OFF_PENDING       = 12'h00C;
  localparam logic [11:0] OFF_PENDING_CLEAR = 12'h010;
  localparam logic [11:0] OFF_REEVAL_GLOBAL = 12'h014;
  localparam logic [11:0] OFF_EVT_STATUS    = 12'h018;
  localparam logic [11:0] OFF_EVT_MASK      = 12'h01C;
  localparam logic [11:0] OFF_REEVAL_SHADOW = 12'h020;
  localparam logic [11:0] REEVAL_STRIDE     = 12'h004;

  // ---------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------
  localparam int          REEVAL_TRIGGER_BIT = 0;
  localparam int          REEVAL_RSVD_BIT    = 1;
  localparam int          EVT_CODE_TAKEN_BIT = 0;
  localparam int          EVT_CODE_RANGE_BIT = 1;
  localparam int          EVT_IRQ_PULSED_BIT = 2;
  localparam int          EVT_WIDTH          = 3;
  localparam logic [31:0] RST_ENABLE_BITS    = 32'h0000_0000;
  localparam logic [31:0] RST_PENDING        = 32'h0000_0000;
  localparam logic [2:0]  RST_EVT            = 3'h0;
  localparam logic [31:0] RDATA_ZERO         = 32'h0000_0000;
  localparam int          CODE_WIDTH         = 6;

  // ---------------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic                  valid;        // one-cycle strobe
    logic                  intermediate; // 1: intermediate completion, 0: final
    logic                  early;        // 1: early completion from channel side
    logic                  final_opt;    // final_completion_irq_option of the channel
    logic                  inter_opt;    // intermediate_completion_irq_option
    logic [CODE_WIDTH-1:0] code;         // completion_code_field of channel_option_word
  } dcirq_cmpl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dcirq_apb_req_t;

endpackage : dcirq_pkg

// file: src/dcirq_regs.sv
// design: completion code interrupt registers with apb slave and per-region pulses
// Function
// RL1 - a one written to enable-clear clears that enable bit; zeros ignored
// RL2 - a one written to enable-set sets that enable bit; zeros ignored
// RL3 - a code is taken only when the matching completion option bit is one
// RL4 - the taken code is the completion code field of the channel option word
// RL5 - a taken code n in 0..31 sets pending bit n
// RL6 - pending bits stay set until software clears them
// RL7 - a one written to pending-clear clears that pending bit; zeros ignored
// RL8 - no further interrupt until every pending bit has been cleared
// RL9 - the reevaluate register exists globally and once per shadow region
// RL10 - shadow reevaluate copies are always accessible, regardless of region enables
// RL11 - reevaluate: bit 0 trigger, bit 1 reserved, rest read zero, reset zero
// RL12 - trigger write pulses that region's interrupt if an enabled bit is pending
// RL13 - software writes zero to reserved reevaluate bit 1
// RL14 - enable bits change only through the set and clear registers
// RL15 - interrupt raised when some bit is both pending and enabled
//
// Our own choices: register access over APB and the placing of the registers.
module dcirq_regs #(
  parameter int NUM_SHADOW = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire dcirq_pkg::dcirq_apb_req_t apb_req,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire dcirq_pkg::dcirq_cmpl_t    cmpl_in,
  output logic [NUM_SHADOW:0]           cmpl_irq_pulse,
  output logic                          evt_irq
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [31:0]                     enable_r,  enable_nxt;
  logic [31:0]                     pending_r, pending_nxt;
  logic                            armed_r,   armed_nxt;
  logic [NUM_SHADOW:0]             pulse_r,   pulse_nxt;
  logic [dcirq_pkg::EVT_WIDTH-1:0] status_r,  status_nxt;
  logic [dcirq_pkg::EVT_WIDTH-1:0] mask_r,    mask_nxt;
  logic                            irq_r,     irq_nxt;
  logic                            ready_r,   ready_nxt;
  logic [31:0]                     rdata_r,   rdata_nxt;
  logic                            err_r,     err_nxt;

  // ---------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------
  logic                wr_en;
  logic                rd_en;
  logic                hit_shadow;
  logic [11:0]         shadow_off;
  logic [11:0]         shadow_idx;
  logic [NUM_SHADOW:0] reevaluate_trigger_wr;
  logic                mapped;
  logic [31:0]         ien_clr;
  logic [31:0]         ien_set;
  logic [31:0]         pend_clr;
  logic [31:0]         code_vec;
  logic                code_ok;
  logic                code_in_range;
  logic                any_live;
  logic                fire;

  // one wait state: pready is registered, so every access takes two access cycles
  assign wr_en      = apb_req.psel & apb_req.penable & ready_r & apb_req.pwrite;
  assign rd_en      = apb_req.psel & apb_req.penable & ~ready_r & ~apb_req.pwrite;
  assign shadow_off = apb_req.paddr - dcirq_pkg::OFF_REEVAL_SHADOW;
  assign shadow_idx = shadow_off >> 2;
  // shadow copies have no region access gate at all
  assign hit_shadow = (apb_req.paddr >= dcirq_pkg::OFF_REEVAL_SHADOW)  //RL10
                    && (apb_req.paddr[1:0] == 2'b00)
                    && (shadow_idx < 12'(NUM_SHADOW));

  always_comb
  begin
    reevaluate_trigger_wr = '0;
    // index 0 is the global copy, 1..NUM_SHADOW the shadow copies
    if (wr_en && apb_req.paddr == dcirq_pkg::OFF_REEVAL_GLOBAL)
    begin
      reevaluate_trigger_wr[0] = apb_req.pwdata[dcirq_pkg::REEVAL_TRIGGER_BIT];  //RL9
    end
    for (int r = 0; r < NUM_SHADOW; r++)
    begin
      if (wr_en && hit_shadow && shadow_idx == 12'(r))
      begin
        reevaluate_trigger_wr[r+1] = apb_req.pwdata[dcirq_pkg::REEVAL_TRIGGER_BIT];  //RL9
      end
    end
  end

  always_comb
  begin
    unique case (apb_req.paddr)
      dcirq_pkg::OFF_ENABLE_BITS,
      dcirq_pkg::OFF_ENABLE_CLEAR,
      dcirq_pkg::OFF_ENABLE_SET,
      dcirq_pkg::OFF_PENDING,
      dcirq_pkg::OFF_PENDING_CLEAR,
      dcirq_pkg::OFF_REEVAL_GLOBAL,
      dcirq_pkg::OFF_EVT_STATUS,
      dcirq_pkg::OFF_EVT_MASK:      mapped = 1'b1;
      default:                      mapped = hit_shadow;
    endcase
  end

  // the enable word itself has no write path
  assign ien_clr  = (wr_en && apb_req.paddr == dcirq_pkg::OFF_ENABLE_CLEAR)
                  ? apb_req.pwdata : '0;  //RL14
  assign ien_set  = (wr_en && apb_req.paddr == dcirq_pkg::OFF_ENABLE_SET)
                  ? apb_req.pwdata : '0;
  assign pend_clr = (wr_en && apb_req.paddr == dcirq_pkg::OFF_PENDING_CLEAR)
                  ? apb_req.pwdata : '0;

  // ---------------------------------------------------------------------
  // completion code intake
  // ---------------------------------------------------------------------
  assign code_ok = cmpl_in.valid
                 && (cmpl_in.intermediate ? cmpl_in.inter_opt : cmpl_in.final_opt);  //RL3
  // codes 32..63 have no pending bit and are only flagged
  assign code_in_range = (cmpl_in.code < 6'h20);

  always_comb
  begin
    code_vec = '0;
    if (code_ok && code_in_range)
    begin
      code_vec[cmpl_in.code[4:0]] = 1'b1;  //RL4 RL5
    end
  end

  // ---------------------------------------------------------------------
  // enable, pending and interrupt generation
  // ---------------------------------------------------------------------
  assign any_live = |(pending_r & enable_r);  //RL15
  assign fire     = armed_r & any_live;

  always_comb
  begin
    enable_nxt  = (enable_r & ~ien_clr) | ien_set;  //RL1 RL2
    // a code arriving with its own clear keeps the bit set
    pending_nxt = (pending_r & ~pend_clr) | code_vec;  //RL6 RL7
    armed_nxt   = armed_r;
    if (fire)
    begin
      armed_nxt = 1'b0;  //RL8
    end
    else if (pending_r == '0)
    begin
      armed_nxt = 1'b1;  //RL8
    end
    pulse_nxt = '0;
    for (int r = 0; r <= NUM_SHADOW; r++)
    begin
      // reevaluate pulses only its own region; bit 1 of the word is ignored
      pulse_nxt[r] = fire | (reevaluate_trigger_wr[r] & any_live);  //RL12 RL15
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable_r  <= dcirq_pkg::RST_ENABLE_BITS;
      pending_r <= dcirq_pkg::RST_PENDING;
      armed_r   <= 1'b1;
      pulse_r   <= '0;
    end
    else
    begin
      enable_r  <= enable_nxt;
      pending_r <= pending_nxt;
      armed_r   <= armed_nxt;
      pulse_r   <= pulse_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // block event status, mask and level interrupt
  // ---------------------------------------------------------------------
  always_comb
  begin
    logic [dcirq_pkg::EVT_WIDTH-1:0] evt_set;
    logic [dcirq_pkg::EVT_WIDTH-1:0] evt_clr;
    evt_set = '0;
    evt_clr = '0;
    evt_set[dcirq_pkg::EVT_CODE_TAKEN_BIT] = code_ok & code_in_range;
    evt_set[dcirq_pkg::EVT_CODE_RANGE_BIT] = code_ok & ~code_in_range;
    evt_set[dcirq_pkg::EVT_IRQ_PULSED_BIT] = |pulse_nxt;
    if (wr_en && apb_req.paddr == dcirq_pkg::OFF_EVT_STATUS)
    begin
      evt_clr = apb_req.pwdata[dcirq_pkg::EVT_WIDTH-1:0];
    end
    // set wins over a same-cycle clear
    status_nxt = (status_r & ~evt_clr) | evt_set;
    mask_nxt   = mask_r;
    if (wr_en && apb_req.paddr == dcirq_pkg::OFF_EVT_MASK)
    begin
      mask_nxt = apb_req.pwdata[dcirq_pkg::EVT_WIDTH-1:0];
    end
    irq_nxt = |(status_r & mask_r);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_r <= dcirq_pkg::RST_EVT;
      mask_r   <= dcirq_pkg::RST_EVT;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------------
  always_comb
  begin
    ready_nxt = apb_req.psel & apb_req.penable & ~ready_r;
    err_nxt   = ready_nxt & ~mapped;
    rdata_nxt = dcirq_pkg::RDATA_ZERO;
    // write-only words, including every reevaluate copy, read as zero
    if (rd_en)
    begin
      unique case (apb_req.paddr)
        dcirq_pkg::OFF_ENABLE_BITS: rdata_nxt = enable_r;
        dcirq_pkg::OFF_PENDING:     rdata_nxt = pending_r;
        dcirq_pkg::OFF_EVT_STATUS:  rdata_nxt = 32'(status_r);
        dcirq_pkg::OFF_EVT_MASK:    rdata_nxt = 32'(mask_r);
        default:                    rdata_nxt = dcirq_pkg::RDATA_ZERO;  //RL11
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ready_r <= 1'b0;
      rdata_r <= dcirq_pkg::RDATA_ZERO;
      err_r   <= 1'b0;
    end
    else
    begin
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign pready         = ready_r;
  assign prdata         = rdata_r;
  assign pslverr        = err_r;
  assign cmpl_irq_pulse = pulse_r;
  assign evt_irq        = irq_r;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  enable_clear_a: assert property (wr_en && apb_req.paddr == dcirq_pkg::OFF_ENABLE_CLEAR //RL1
    |=> (enable_r & $past(apb_req.pwdata)) == '0)
    else $error("enable bit survived a clear write");
  enable_set_a: assert property (wr_en && apb_req.paddr == dcirq_pkg::OFF_ENABLE_SET //RL2
    |=> (enable_r & $past(apb_req.pwdata)) == $past(apb_req.pwdata))
    else $error("enable bit not set by a set write");
  enable_hold_a: assert property (!(wr_en && (apb_req.paddr == dcirq_pkg::OFF_ENABLE_SET //RL14
    || apb_req.paddr == dcirq_pkg::OFF_ENABLE_CLEAR)) |=> $stable(enable_r))
    else $error("enable word changed without a set or clear write");
  code_gate_a: assert property (cmpl_in.valid && !code_ok && pending_r == '0 //RL3
    && pend_clr == '0 |=> pending_r == '0)
    else $error("code taken with its option bit off");
  pending_set_a: assert property (code_ok && code_in_range //RL4 RL5
    |=> pending_r[$past(cmpl_in.code[4:0])])
    else $error("pending bit not set by its completion code");
  pending_sticky_a: assert property (pending_r != '0 && pend_clr == '0 //RL6
    |=> (pending_r & $past(pending_r)) == $past(pending_r))
    else $error("pending bit dropped without software clear");
  pending_clear_a: assert property (pend_clr != '0 && !code_ok //RL7
    |=> (pending_r & $past(pend_clr)) == '0)
    else $error("pending bit survived a clear write");
  rearm_block_a: assert property (fire ##1 (pending_r != '0 && reevaluate_trigger_wr == '0) //RL8
    |=> cmpl_irq_pulse == '0)
    else $error("second interrupt while bits still pending");
  reevaluate_trigger_pulse_a: assert property (reevaluate_trigger_wr[0] && any_live //RL12
    |=> cmpl_irq_pulse[0])
    else $error("reevaluate write did not pulse its region");
  reevaluate_trigger_quiet_a: assert property (reevaluate_trigger_wr != '0 && !any_live //RL12 RL15
    |=> cmpl_irq_pulse == '0)
    else $error("pulse without enabled pending bit");
  reevaluate_trigger_read_a: assert property (rd_en && apb_req.paddr == dcirq_pkg::OFF_REEVAL_GLOBAL //RL11
    |=> pready && prdata == '0)
    else $error("reevaluate register read nonzero");

  first_irq_c:   cover property (fire ##1 cmpl_irq_pulse[0]);
  shadow_reevaluate_trigger_c: cover property (reevaluate_trigger_wr[NUM_SHADOW] && any_live);
  same_cycle_c:  cover property (code_ok && pend_clr != '0);
  evt_irq_c:     cover property (evt_irq);

endmodule : dcirq_regs

// file: testbench/dcirq_cmpl_model.sv
// partner model: far side that returns completion codes to the interrupt block
module dcirq_cmpl_model (
  input  wire logic            clk,
  output dcirq_pkg::dcirq_cmpl_t cmpl_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial cmpl_out = '0;

  // ---------------------------------------------------------------------
  // one code per call, strobe one cycle
  // ---------------------------------------------------------------------
  // code, intermediate and early go inverted and both option bits take !channel_option_word once the strobe drops so stale values never look valid
  task automatic send(input logic [dcirq_pkg::CODE_WIDTH-1:0] code, input logic inter,
                      input logic early, input logic channel_option_word);
    @(posedge clk);
    cmpl_out <= '{1'b1, inter, early, !inter && channel_option_word, inter && channel_option_word, code};
    @(posedge clk);
    cmpl_out <= '{1'b0, !inter, !early, !channel_option_word, !channel_option_word, ~code};
  endtask : send
endmodule : dcirq_cmpl_model

// file: testbench/dcirq_regs_tb.sv
// testbench: register, completion code and pulse checks of the completion interrupt block
module dcirq_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      clk;
  logic                      rst;
  logic                      pready;
  logic                      pslverr;
  logic                      evt_irq;
  logic                      err_v;
  logic [31:0]               prdata;
  logic [31:0]               rd_v;
  logic [4:0]                cmpl_irq_pulse;
  dcirq_pkg::dcirq_apb_req_t apb_req;
  dcirq_pkg::dcirq_cmpl_t    cmpl_in;
  int                        num_errors = 0;
  int                        cmp_count = 0;
  int                        cyc = 0;
  int                        pc[5] = '{default: 0};
  int                        sn[5] = '{default: 0};

  dcirq_regs #(.NUM_SHADOW(4)) dcirq_regs_i (.clk(clk), .rst(rst), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmpl_in(cmpl_in),
    .cmpl_irq_pulse(cmpl_irq_pulse), .evt_irq(evt_irq));
  dcirq_cmpl_model dcirq_cmpl_model_i (.clk(clk), .cmpl_out(cmpl_in));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------
  // pulse counting and hang guard
  // ---------------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    for (int i = 0; i < 5; i++) if (cmpl_irq_pulse[i] === 1'b1) pc[i]++;
    if (cyc == 5000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------------
  // request held until the edge that samples pready; the bench timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp);
    chk({31'h0000_0000, err_v}, 32'h0000_0000);
  endtask : rd

  // pulses seen per region since the last call, against a one-per-bit mask
  task automatic pulses(input logic [4:0] exp);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      cmp_count++;
      if (pc[i] - sn[i] != int'(exp[i]))
      begin
        num_errors++;
        $display("BAD %0t: region %0d pulse count %0d", $time, i, pc[i] - sn[i]);
      end
      sn[i] = pc[i];
    end
  endtask : pulses

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    logic [11:0] ra;
    rst = 1'b1;
    apb_req = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(dcirq_pkg::OFF_ENABLE_BITS, 32'h0000_0000);
    rd(dcirq_pkg::OFF_PENDING, 32'h0000_0000);
    wr(dcirq_pkg::OFF_ENABLE_SET, 32'h8000_0009);
    wr(dcirq_pkg::OFF_ENABLE_BITS, 32'hFFFF_FFFF);
    rd(dcirq_pkg::OFF_ENABLE_BITS, 32'h8000_0009);
    wr(dcirq_pkg::OFF_ENABLE_CLEAR, 32'h0000_0001);
    rd(dcirq_pkg::OFF_ENABLE_BITS, 32'h8000_0008);
    rd(dcirq_pkg::OFF_ENABLE_CLEAR, 32'h0000_0000);
    dcirq_cmpl_model_i.send(6'h05, 1'b0, 1'b0, 1'b0);
    dcirq_cmpl_model_i.send(6'h03, 1'b0, 1'b0, 1'b1);
    pulses(5'h1F);
    rd(dcirq_pkg::OFF_PENDING, 32'h0000_0008);
    dcirq_cmpl_model_i.send(6'h1F, 1'b1, 1'b1, 1'b1);
    pulses(5'h00);
    dcirq_cmpl_model_i.send(6'h28, 1'b0, 1'b0, 1'b1);
    rd(dcirq_pkg::OFF_PENDING, 32'h8000_0008);
    rd(dcirq_pkg::OFF_EVT_STATUS, 32'h0000_0007);
    chk({31'h0000_0000, evt_irq}, 32'h0000_0000);
    wr(dcirq_pkg::OFF_EVT_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, evt_irq}, 32'h0000_0001);
    wr(dcirq_pkg::OFF_EVT_STATUS, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, evt_irq}, 32'h0000_0000);
    rd(dcirq_pkg::OFF_EVT_STATUS, 32'h0000_0000);
    wr(dcirq_pkg::OFF_PENDING_CLEAR, 32'h0000_0008);
    rd(dcirq_pkg::OFF_PENDING, 32'h8000_0000);
    // bit 31 still pending and enabled, so every region copy must fire alone
    for (int r = 0; r < 5; r++)
    begin
      ra = (r == 0) ? dcirq_pkg::OFF_REEVAL_GLOBAL
                    : 12'(dcirq_pkg::OFF_REEVAL_SHADOW + dcirq_pkg::REEVAL_STRIDE * (r - 1));
      wr(ra, 32'h0000_0001);
      pulses(5'(1 << r));
      wr(ra, 32'h0000_0000);
      pulses(5'h00);
      rd(ra, 32'h0000_0000);
    end
    wr(dcirq_pkg::OFF_PENDING_CLEAR, 32'hFFFF_FFFF);
    rd(dcirq_pkg::OFF_PENDING, 32'h0000_0000);
    wr(dcirq_pkg::OFF_REEVAL_GLOBAL, 32'h0000_0001);
    pulses(5'h00);
    dcirq_cmpl_model_i.send(6'h03, 1'b0, 1'b0, 1'b1);
    pulses(5'h1F);
    // code and its own clear meet in one cycle: the set must win
    fork
      wr(dcirq_pkg::OFF_PENDING_CLEAR, 32'h0000_0008);
      begin
        repeat (2) @(posedge clk);
        dcirq_cmpl_model_i.send(6'h03, 1'b0, 1'b0, 1'b1);
      end
    join
    rd(dcirq_pkg::OFF_PENDING, 32'h0000_0008);
    // reset in mid-run brings the enable, pending and event status words back to their reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(dcirq_pkg::OFF_ENABLE_BITS, 32'h0000_0000);
    rd(dcirq_pkg::OFF_PENDING, 32'h0000_0000);
    rd(dcirq_pkg::OFF_EVT_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({31'h0000_0000, err_v}, 32'h0000_0001);
    chk(rd_v, 32'h0000_0000);
    close_out();
  end
endmodule : dcirq_regs_tb
